// file: design/mcc_top.sv
// Purpose: Command, transmit config and receive config registers of the MAC
// Assumes: APB slave, EEPROM reached through a word request port
// Notes: Byte registers sit in bits 7:0 of their word
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module mcc_top (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // EEPROM word port
    output logic ee_req,
    output logic ee_we,
    output logic [5:0] ee_addr,
    output logic [15:0] ee_wdata,
    input wire logic ee_ack,
    input wire logic [15:0] ee_rdata,
    // MAC core control
    output logic receive_enable,
    output logic transmit_enable,
    output logic fifo_reinit,
    output logic append_fcs,
    output logic [11:0] ifg_cycles,
    input wire logic speed_100,
    // Transmit collision handling
    input wire logic tx_start,
    input wire logic tx_collision,
    output logic tx_abort,
    // Receive filtering
    input wire logic rx_frame_end,
    input wire logic [47:0] rx_dest,
    input wire logic [5:0] rx_hash_idx,
    input wire logic rx_crc_ok,
    input wire logic rx_short,
    output logic rx_decide,
    output logic rx_accept,
    output logic rx_tail_hdr,
    // Interrupt endpoint counter
    input wire logic perf_event,
    input wire logic ep3_access,
    output logic [15:0] perf_count
);
    import mcc_pkg::*;

    mcc_state_t state_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;
    logic ee_req_r, ee_we_r;
    logic [5:0] ee_addr_r;
    logic [15:0] ee_wdata_r;
    logic [7:0] station_r [6];
    logic [7:0] mcast_r [8];
    logic [7:0] cmd_r, tcfg_r, rcfg_r;
    logic excol_r;
    logic [15:0] srst_cnt_r;
    logic load_pend_r;
    logic [1:0] load_word_r;
    logic [6:0] retry_cnt_r;
    logic tx_abort_r, rx_decide_r, rx_accept_r;
    logic fifo_reinit_r, append_fcs_r, rx_tail_r;
    logic [11:0] ifg_r, ifg_nxt;
    logic [15:0] perf_r;

    logic [13:0] idx;
    logic access, wr_done, rd_done, in_win, mapped;
    logic [7:0] reg_rd;
    logic [6:0] retry_limit;
    logic accept_nxt, is_mcast, is_bcast, is_own;

    assign idx = paddr[15:2];
    assign access = psel && penable;
    assign wr_done = access && pready_r && pwrite;
    assign rd_done = access && pready_r && !pwrite;
    assign in_win = idx >= IDX_EE_LO && idx <= IDX_EE_HI;

    // Register read mux
    always_comb begin
        reg_rd = 8'h00;
        mapped = 1'b1;
        if (idx >= IDX_STATION && idx < IDX_MCAST) begin
            reg_rd = station_r[3'(idx - IDX_STATION)];
        end else if (idx >= IDX_MCAST && idx < IDX_CMD) begin
            reg_rd = mcast_r[3'(idx - IDX_MCAST)];
        end else if (idx == IDX_CMD) begin
            reg_rd = cmd_r & CMD_MASK;
        end else if (idx == IDX_TCFG) begin
            reg_rd = tcfg_r & TCFG_MASK;
        end else if (idx == IDX_RCFG) begin
            reg_rd = rcfg_r & RCFG_MASK;
        end else if (idx == IDX_RCFG + 14'h1) begin
            reg_rd = 8'h00;
        end else if (idx == IDX_TSTAT) begin
            reg_rd[TSTAT_EXCOL] = excol_r;
        end else begin
            mapped = in_win;
        end
    end

    // Bus and EEPROM sequencing
    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= MCC_IDLE;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
            ee_req_r <= 1'b0;
            ee_we_r <= 1'b0;
            ee_addr_r <= 6'h00;
            ee_wdata_r <= 16'h0000;
            load_word_r <= 2'd0;
        end else begin
            pready_r <= 1'b0;
            unique case (state_r)
                MCC_IDLE: begin
                    if (load_pend_r && !access) begin
                        state_r <= MCC_LOAD;
                        load_word_r <= 2'd0;
                        ee_req_r <= 1'b1;
                        ee_we_r <= 1'b0;
                        ee_addr_r <= EE_STATION_WORD;
                    end else if (access && !pready_r) begin
                        if (in_win && (!pwrite || cmd_r[CMD_EEWE])) begin
                            state_r <= MCC_BUS;
                            ee_req_r <= 1'b1;
                            ee_we_r <= pwrite;
                            ee_addr_r <= 6'((idx - IDX_EE_LO) >> 1);
                            ee_wdata_r <= pwdata[15:0];
                        end else begin
                            pready_r <= 1'b1;
                            pslverr_r <= !mapped;
                            prdata_r <= {24'h0, reg_rd};
                        end
                    end
                end
                MCC_BUS: begin
                    if (ee_ack) begin
                        state_r <= MCC_IDLE;
                        ee_req_r <= 1'b0;
                        pready_r <= 1'b1;
                        pslverr_r <= 1'b0;
                        prdata_r <= ee_we_r ? 32'h0 :
                            (paddr[2] ? {24'h0, ee_rdata[15:8]} : {16'h0, ee_rdata});
                    end
                end
                MCC_LOAD: begin
                    if (ee_ack) begin
                        if (load_word_r == STATION_WORDS - 2'd1) begin
                            state_r <= MCC_IDLE;
                            ee_req_r <= 1'b0;
                        end else begin
                            load_word_r <= load_word_r + 2'd1;
                            ee_addr_r <= ee_addr_r + 6'd1;
                        end
                    end
                end
                default: state_r <= MCC_IDLE;
            endcase
        end
    end

    // Station address and multicast filter
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < 6; i++) begin
                station_r[i] <= RESET_BYTE;
            end
            for (int i = 0; i < 8; i++) begin
                mcast_r[i] <= RESET_BYTE;
            end
        end else if (state_r == MCC_LOAD && ee_ack) begin
            station_r[{load_word_r, 1'b0}] <= ee_rdata[7:0];
            station_r[{load_word_r, 1'b1}] <= ee_rdata[15:8];
        end else if (wr_done && idx >= IDX_STATION && idx < IDX_MCAST) begin
            station_r[3'(idx - IDX_STATION)] <= pwdata[7:0];
        end else if (wr_done && idx >= IDX_MCAST && idx < IDX_CMD) begin
            mcast_r[3'(idx - IDX_MCAST)] <= pwdata[7:0];
        end
    end

    // Command register
    always_ff @(posedge clock) begin
        if (rst) begin
            cmd_r <= RESET_BYTE;
            srst_cnt_r <= 16'h0;
            load_pend_r <= 1'b1;
        end else begin
            if (srst_cnt_r != 16'h0) begin
                srst_cnt_r <= srst_cnt_r - 16'h1;
            end
            if (state_r == MCC_LOAD && ee_ack && load_word_r == STATION_WORDS - 2'd1) begin
                cmd_r[CMD_LOAD] <= 1'b0;
            end
            if (state_r == MCC_LOAD) begin
                load_pend_r <= 1'b0;
            end
            if (wr_done && idx == IDX_CMD) begin
                cmd_r <= pwdata[7:0] & CMD_MASK;
                if (pwdata[CMD_LOAD]) begin
                    load_pend_r <= 1'b1;
                end
                if (pwdata[CMD_SRST]) begin
                    srst_cnt_r <= SRST_CYCLES;
                    cmd_r[CMD_RXEN] <= 1'b0;
                    cmd_r[CMD_TXEN] <= 1'b0;
                end
            end else if (srst_cnt_r == 16'h1) begin
                cmd_r[CMD_SRST] <= 1'b0;
            end
            if (srst_cnt_r != 16'h0 && !(wr_done && idx == IDX_CMD)) begin
                cmd_r[CMD_RXEN] <= 1'b0;
                cmd_r[CMD_TXEN] <= 1'b0;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clock) begin
        if (rst) begin
            tcfg_r <= RESET_BYTE;
            rcfg_r <= RESET_BYTE;
        end else if (wr_done && idx == IDX_TCFG) begin
            tcfg_r <= pwdata[7:0] & TCFG_MASK;
        end else if (wr_done && idx == IDX_RCFG) begin
            rcfg_r <= pwdata[7:0] & RCFG_MASK;
        end
    end

    // MAC control outputs
    always_comb begin
        if (speed_100) begin
            ifg_nxt = IFG100_BASE_CYC + IFG100_STEP_CYC * {10'h0, tcfg_r[4:3]};
        end else begin
            ifg_nxt = IFG10_BASE_CYC + IFG10_STEP_CYC * {10'h0, tcfg_r[4:3]};
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            fifo_reinit_r <= 1'b0;
            append_fcs_r <= 1'b1;
            rx_tail_r <= 1'b0;
            ifg_r <= IFG10_BASE_CYC;
        end else begin
            fifo_reinit_r <= srst_cnt_r != 16'h0;
            append_fcs_r <= !tcfg_r[TCFG_OMIT];
            rx_tail_r <= rcfg_r[RCFG_TAIL];
            ifg_r <= ifg_nxt;
        end
    end

    // Collision retries and excessive collision flag
    assign retry_limit = RETRY_BASE + {tcfg_r[7:6], 4'h0};

    always_ff @(posedge clock) begin
        if (rst) begin
            retry_cnt_r <= 7'd0;
            tx_abort_r <= 1'b0;
        end else begin
            tx_abort_r <= 1'b0;
            if (tx_start || srst_cnt_r != 16'h0) begin
                retry_cnt_r <= 7'd0;
            end else if (tx_collision && cmd_r[CMD_TXEN]) begin
                if (retry_cnt_r == retry_limit) begin
                    tx_abort_r <= 1'b1;
                    retry_cnt_r <= 7'd0;
                end else begin
                    retry_cnt_r <= retry_cnt_r + 7'd1;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            excol_r <= 1'b0;
        end else if (tx_abort_r) begin
            excol_r <= 1'b1;
        end else if ((rd_done && idx == IDX_TSTAT) || ep3_access) begin
            excol_r <= 1'b0;
        end
    end

    // Receive acceptance filter
    assign is_bcast = &rx_dest;
    assign is_mcast = rx_dest[0] && !is_bcast;
    assign is_own = rx_dest == {station_r[5], station_r[4], station_r[3],
                                station_r[2], station_r[1], station_r[0]};

    always_comb begin
        accept_nxt = 1'b0;
        if (is_bcast) begin
            accept_nxt = rcfg_r[RCFG_BCAST];
        end else if (is_mcast) begin
            accept_nxt = rcfg_r[RCFG_ANYMC] ||
                (rcfg_r[RCFG_HASHMC] && mcast_r[rx_hash_idx[5:3]][rx_hash_idx[2:0]]);
        end else begin
            accept_nxt = rcfg_r[RCFG_PROMISC] || (rcfg_r[RCFG_AD] && is_own);
        end
        if (!rx_crc_ok && !rcfg_r[RCFG_BADFCS]) begin
            accept_nxt = 1'b0;
        end
        if (rx_short && !rcfg_r[RCFG_SHORT]) begin
            accept_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rx_decide_r <= 1'b0;
            rx_accept_r <= 1'b0;
        end else begin
            rx_decide_r <= rx_frame_end && cmd_r[CMD_RXEN];
            rx_accept_r <= rx_frame_end && cmd_r[CMD_RXEN] && accept_nxt;
        end
    end

    // Interrupt endpoint performance counter
    always_ff @(posedge clock) begin
        if (rst) begin
            perf_r <= 16'h0;
        end else if (ep3_access && cmd_r[CMD_CLREN]) begin
            perf_r <= {15'h0, perf_event};
        end else if (perf_event) begin
            perf_r <= perf_r + 16'h1;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign ee_req = ee_req_r;
    assign ee_we = ee_we_r;
    assign ee_addr = ee_addr_r;
    assign ee_wdata = ee_wdata_r;
    assign receive_enable = cmd_r[CMD_RXEN];
    assign transmit_enable = cmd_r[CMD_TXEN];
    assign fifo_reinit = fifo_reinit_r;
    assign append_fcs = append_fcs_r;
    assign ifg_cycles = ifg_r;
    assign tx_abort = tx_abort_r;
    assign rx_decide = rx_decide_r;
    assign rx_accept = rx_accept_r;
    assign rx_tail_hdr = rx_tail_r;
    assign perf_count = perf_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_win_guard;
        ee_req && ee_we |-> cmd_r[CMD_EEWE];
    endproperty
    a_win_guard: assert property (p_win_guard) else $error("EEPROM write while disabled");

    property p_win_map;
        $rose(ee_req) && state_r == MCC_BUS |-> ee_addr == 6'((idx - IDX_EE_LO) >> 1);
    endproperty
    a_win_map: assert property (p_win_map) else $error("EEPROM window offset wrong");

    property p_srst;
        wr_done && idx == IDX_CMD && pwdata[CMD_SRST] |=> cmd_r[CMD_SRST] && !receive_enable
            && !transmit_enable ##1 fifo_reinit;
    endproperty
    a_srst: assert property (p_srst) else $error("Soft reset did not take hold");

    property p_srst_end;
        srst_cnt_r == 16'h1 && !wr_done |=> !cmd_r[CMD_SRST];
    endproperty
    a_srst_end: assert property (p_srst_end) else $error("Soft reset bit not cleared");

    property p_abort;
        tx_collision && !tx_start && transmit_enable && retry_cnt_r == retry_limit
            && srst_cnt_r == 16'h0 |=> tx_abort ##1 excol_r;
    endproperty
    a_abort: assert property (p_abort) else $error("Retry exhaustion not flagged");

    property p_no_abort;
        tx_abort |-> $past(retry_cnt_r) >= RETRY_BASE;
    endproperty
    a_no_abort: assert property (p_no_abort) else $error("Abort before sixteen retries");

    property p_fcs;
        ##1 $stable(tcfg_r) |=> append_fcs == !$past(tcfg_r[TCFG_OMIT]);
    endproperty
    a_fcs: assert property (p_fcs) else $error("Frame check append wrong");

    property p_bcast;
        rx_frame_end && receive_enable && is_bcast && !rcfg_r[RCFG_BCAST] |=> !rx_accept;
    endproperty
    a_bcast: assert property (p_bcast) else $error("Broadcast accepted while rejected");

    property p_runt;
        rx_frame_end && rx_short && !rcfg_r[RCFG_SHORT] |=> !rx_accept;
    endproperty
    a_runt: assert property (p_runt) else $error("Short frame accepted");

    property p_perf_clr;
        ep3_access && cmd_r[CMD_CLREN] && !perf_event |=> perf_count == 16'h0;
    endproperty
    a_perf_clr: assert property (p_perf_clr) else $error("Counter not cleared");

    c_load: cover property (state_r == MCC_LOAD ##[1:50] state_r == MCC_IDLE);
    c_abort: cover property (tx_abort);
    c_win_wr: cover property (ee_req && ee_we ##[1:50] pready);
    c_accept: cover property (rx_decide && rx_accept);
endmodule

// file: design/mcc_pkg.sv
// Purpose: Constants for the MAC command, transmit and receive config block
// Assumes: APB with 32-bit data, one byte register per word, 200 MHz clock
// Notes: Register byte address is four times the register index
// Overview of operation
// - Window writes program EEPROM only when enabled
// - Window start maps to EEPROM offset zero
// - Soft reset stops MAC, keeps addresses
// - Soft reset bit reads 1 until done
// - Command bits enable receiver and transmitter
// - Optionally clear performance counter after endpoint access
// - Reload bit reloads from EEPROM, self clears
// - Collision retries are 16 plus 16 per count
// - Retry exhaustion sets excessive collision flag
// - Gap field sets interframe gap per speed
// - Omit bit suppresses appended frame check
// - Tail bit puts header over check bytes
// - Accept frames failing check when enabled
// - Accept short frames only when enabled
// - Accept multicast selected by filter
// - Accept station match and broadcast by bits
// - Accept every multicast when enabled
// - Promiscuous mode accepts every physical frame
// - Station address sits at its offsets, loaded
// - Excessive collision is status bit five
package mcc_pkg;
    localparam logic [13:0] IDX_STATION = 14'h0120;
    localparam logic [13:0] IDX_MCAST = 14'h0126;
    localparam logic [13:0] IDX_CMD = 14'h012e;
    localparam logic [13:0] IDX_TCFG = 14'h012f;
    localparam logic [13:0] IDX_RCFG = 14'h0130;
    localparam logic [13:0] IDX_TSTAT = 14'h0132;
    localparam logic [13:0] IDX_EE_LO = 14'h1200;
    localparam logic [13:0] IDX_EE_HI = 14'h127f;
    localparam int CMD_EEWE = 5;
    localparam int CMD_SRST = 4;
    localparam int CMD_RXEN = 3;
    localparam int CMD_TXEN = 2;
    localparam int CMD_CLREN = 1;
    localparam int CMD_LOAD = 0;
    localparam logic [7:0] CMD_MASK = 8'h3f;
    localparam logic [7:0] TCFG_MASK = 8'hd9;
    localparam logic [7:0] RCFG_MASK = 8'hff;
    localparam int TCFG_OMIT = 0;
    localparam int RCFG_TAIL = 7;
    localparam int RCFG_BADFCS = 6;
    localparam int RCFG_SHORT = 5;
    localparam int RCFG_HASHMC = 4;
    localparam int RCFG_BCAST = 3;
    localparam int RCFG_AD = 2;
    localparam int RCFG_ANYMC = 1;
    localparam int RCFG_PROMISC = 0;
    localparam int TSTAT_EXCOL = 5;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [6:0] RETRY_BASE = 7'd16;
    localparam int CLK_MHZ = 200;
    localparam int IFG10_BASE_NS = 8400;
    localparam int IFG10_STEP_NS = 400;
    localparam int IFG100_BASE_NS = 840;
    localparam int IFG100_STEP_NS = 40;
    localparam logic [11:0] IFG10_BASE_CYC = 12'((IFG10_BASE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [11:0] IFG10_STEP_CYC = 12'((IFG10_STEP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [11:0] IFG100_BASE_CYC = 12'((IFG100_BASE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [11:0] IFG100_STEP_CYC = 12'((IFG100_STEP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [5:0] EE_STATION_WORD = 6'h00;
    localparam logic [1:0] STATION_WORDS = 2'd3;
    localparam logic [15:0] SRST_CYCLES = 16'd16;
    typedef enum logic [1:0] {MCC_IDLE, MCC_BUS, MCC_LOAD} mcc_state_t;
endpackage

// file: bench/mcc_ee_model.sv
// Purpose: Word-wide serial EEPROM model on the far side of the word port
// Assumes: One request at a time, answered after slow extra cycles
// Notes: Read data is scrambled outside the acknowledge cycle
`timescale 1ns/1ps
module mcc_ee_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Word port
    input wire logic ee_req,
    input wire logic ee_we,
    input wire logic [5:0] ee_addr,
    input wire logic [15:0] ee_wdata,
    output logic ee_ack,
    output logic [15:0] ee_rdata
);
    logic [15:0] mem [64];
    int wait_n = 0;
    int slow = 0;
    int writes = 0;
    initial begin
        for (int i = 0; i < 64; i++) mem[i] = {8'(2 * i + 65), 8'(2 * i + 64)};
        ee_ack = 1'b0;
        ee_rdata = 16'h0000;
    end
    always @(posedge clock) begin
        ee_ack <= 1'b0;
        if (rst) begin
            wait_n <= 0;
        end else if (ee_req && !ee_ack && wait_n >= slow) begin
            ee_ack <= 1'b1;
            wait_n <= 0;
            if (ee_we) begin
                mem[ee_addr] <= ee_wdata; // Whole 16-bit word per write
                writes <= writes + 1;
            end else begin
                ee_rdata <= mem[ee_addr];
            end
        end else begin
            if (ee_req && !ee_ack) wait_n <= wait_n + 1;
            ee_rdata <= ~ee_rdata;
        end
    end
endmodule

// file: bench/mcc_top_bench.sv
// Purpose: Self-checking bench for the command and config register block
// Assumes: APB master tasks, EEPROM model answering the word port
// Notes: Byte address is four times the register index
`timescale 1ns/1ps
module mcc_top_bench;
    import mcc_pkg::*;
    logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, ee_req, ee_we, ee_ack, receive_enable, transmit_enable;
    logic [5:0] ee_addr;
    logic [15:0] ee_wdata, ee_rdata, perf_count;
    logic fifo_reinit, append_fcs, tx_abort, rx_decide, rx_accept, rx_tail_hdr;
    logic [11:0] ifg_cycles;
    logic speed_100 = 0, tx_start = 0, tx_collision = 0, rx_frame_end = 0;
    logic rx_crc_ok = 1, rx_short = 0, perf_event = 0, ep3_access = 0;
    logic [47:0] rx_dest = 48'h0;
    logic [5:0] rx_hash_idx = 6'h00;
    int mismatches = 0, tests_run = 0, cycles = 0;
    always #2.5 clock = ~clock;
    mcc_top dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ee_req(ee_req), .ee_we(ee_we),
        .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_ack(ee_ack), .ee_rdata(ee_rdata),
        .receive_enable(receive_enable), .transmit_enable(transmit_enable),
        .fifo_reinit(fifo_reinit), .append_fcs(append_fcs), .ifg_cycles(ifg_cycles),
        .speed_100(speed_100), .tx_start(tx_start), .tx_collision(tx_collision),
        .tx_abort(tx_abort), .rx_frame_end(rx_frame_end), .rx_dest(rx_dest),
        .rx_hash_idx(rx_hash_idx), .rx_crc_ok(rx_crc_ok), .rx_short(rx_short),
        .rx_decide(rx_decide), .rx_accept(rx_accept), .rx_tail_hdr(rx_tail_hdr),
        .perf_event(perf_event), .ep3_access(ep3_access), .perf_count(perf_count));
    mcc_ee_model eem (.clock(clock), .rst(rst), .ee_req(ee_req), .ee_we(ee_we),
        .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_ack(ee_ack), .ee_rdata(ee_rdata));
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic check(string what, logic [47:0] seen, logic [47:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(logic w, logic [15:0] a, logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clock);
    endtask
    localparam int P_START = 0, P_COLL = 1, P_FEND = 2, P_EVENT = 3, P_EP = 4;
    task automatic drive(int sel, logic v);
        case (sel)
            P_START: tx_start <= v;
            P_COLL: tx_collision <= v;
            P_FEND: rx_frame_end <= v;
            P_EVENT: perf_event <= v;
            default: ep3_access <= v;
        endcase
    endtask
    task automatic pulse(int sel);
        drive(sel, 1'b1);
        @(posedge clock);
        drive(sel, 1'b0);
        @(posedge clock);
    endtask
    task automatic t_reset();
        check("append", append_fcs, 1);
        check("gap", ifg_cycles, 1680);
        apb(0, 16'h04b8, 0);
        check("cmd", rd, 0);
        apb(0, 16'h04c0, 0);
        check("rcfg", rd, 0);
        apb(0, 16'h04c4, 0);
        check("rcfg hi", {err, rd}, 0);
        apb(0, 16'h0480, 0);
        check("sta0", rd, 32'h40);
        apb(0, 16'h0494, 0);
        check("sta5", rd, 32'h45);
    endtask
    task automatic t_cmd();
        apb(1, 16'h04b8, 32'hce);
        apb(0, 16'h04b8, 0);
        check("cmd", rd, 32'h0e);
        check("rxen", {receive_enable, transmit_enable}, 2'b11);
        apb(0, 16'h0010, 0);
        check("unmapped", {err, rd}, 33'h100000000);
        apb(1, 16'h04b8, 32'h1c);
        apb(0, 16'h04b8, 0);
        check("busy", {rd[4], transmit_enable, fifo_reinit}, 3'b101);
        repeat (20) @(posedge clock);
        apb(0, 16'h04b8, 0);
        check("done", rd[4], 0);
        apb(0, 16'h0480, 0);
        check("kept", rd, 32'h40);
    endtask
    task automatic t_tcfg();
        apb(1, 16'h04bc, 32'hff);
        apb(0, 16'h04bc, 0);
        check("tcfg", {append_fcs, rd}, 33'hd9);
        for (int n = 0; n < 4; n++) begin
            apb(1, 16'h04bc, 32'(n << 3));
            speed_100 <= 0;
            repeat (2) @(posedge clock);
            check("gap10", ifg_cycles, 12'(1680 + 80 * n));
            speed_100 <= 1;
            repeat (2) @(posedge clock);
            check("gap100", ifg_cycles, 12'(168 + 8 * n));
        end
    endtask
    task automatic t_coll(int f);
        apb(1, 16'h04b8, 32'h04);
        apb(1, 16'h04bc, 32'(f << 6));
        pulse(P_START);
        for (int i = 1; i <= 17 + 16 * f; i++) begin
            pulse(P_COLL);
            check("abort", tx_abort, i == 17 + 16 * f);
        end
        apb(0, 16'h04c8, 0);
        check("excol", rd[5], 1);
        apb(0, 16'h04c8, 0);
        check("excol clr", rd[5], 0);
    endtask
    task automatic t_rx();
        logic [7:0] cf [12] = '{8'h04, 0, 8'h08, 8'h04, 8'h10, 8'h10, 8'h02, 8'h01,
            8'h04, 8'h44, 8'h04, 8'h24};
        logic [3:0] ds [12] = '{0, 0, 1, 1, 2, 3, 3, 4, 0, 0, 0, 0};
        logic [11:0] bad = 12'h300, shrt = 12'hc00, acc = 12'had5;
        logic [47:0] dv [5] = '{48'h454443424140, '1, 48'h01, 48'h01, 48'ha2};
        apb(1, 16'h04b8, 32'h08);
        apb(1, 16'h0498, 32'h02);
        for (int k = 0; k < 12; k++) begin
            apb(1, 16'h04c0, 32'(cf[k]));
            rx_dest <= dv[ds[k]];
            rx_hash_idx <= (ds[k] == 3) ? 6'h02 : 6'h01;
            rx_crc_ok <= !bad[k];
            rx_short <= shrt[k];
            pulse(P_FEND);
            check("rx", {rx_decide, rx_accept}, {1'b1, acc[k]});
        end
        apb(1, 16'h04c0, 32'h80);
        @(posedge clock);
        check("tail", rx_tail_hdr, 1);
    endtask
    task automatic t_perf();
        apb(1, 16'h04b8, 32'h00);
        repeat (3) pulse(P_EVENT);
        pulse(P_EP);
        check("keep", perf_count, 3);
        apb(1, 16'h04b8, 32'h02);
        pulse(P_EP);
        check("clear", perf_count, 0);
    endtask
    task automatic t_ee();
        eem.slow = 3;
        apb(1, 16'h04b8, 32'h00);
        apb(1, 16'h4810, 32'hbeef);
        check("locked", {eem.writes, eem.mem[2]}, {32'd0, 16'h4544});
        apb(1, 16'h04b8, 32'h20);
        apb(1, 16'h4810, 32'hbeef);
        apb(1, 16'h4800, 32'h1234);
        check("prog", {eem.mem[2], eem.mem[0]}, 32'hbeef1234);
        apb(0, 16'h4800, 0);
        check("wread lo", rd, 32'h1234);
        apb(0, 16'h4814, 0);
        check("wread", rd[7:0], 8'hbe);
        apb(1, 16'h04b8, 32'h01);
        apb(0, 16'h04b8, 0);
        check("reload", rd[0], 0);
        apb(0, 16'h0480, 0);
        check("sta0", rd, 32'h34);
    endtask
    initial begin
        repeat (10) @(posedge clock);
        rst <= 0;
        @(posedge clock);
        t_reset();
        t_cmd();
        t_tcfg();
        t_coll(0);
        t_coll(3);
        t_rx();
        t_perf();
        t_ee();
        print_verdict();
    end
endmodule
